// >>> bench/sbuf_upstream_model.sv
// Upstream model: gated clock pulses with their data bits
`timescale 1ns/10ps
module sbuf_upstream_model
(
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	input  wire logic       i_start,
	input  wire logic [7:0] i_count,
	output logic            o_gated_input_clock,
	output logic            o_channel_data_in,
	output logic            o_busy
);
	logic [7:0] left_reg;   // Pulses still to send
	logic [1:0] gap_reg;    // Spacing between pulses

	// Busy while pulses remain or one is on the line
	assign o_busy = (left_reg != 8'h00) || o_gated_input_clock;

	// One pulse every four cycles; data held only around it
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			left_reg <= 8'h00;
			gap_reg <= 2'h0;
			o_gated_input_clock <= 1'b0;
			o_channel_data_in <= 1'b0;
		end
		else
		begin
			o_gated_input_clock <= 1'b0;
			gap_reg <= gap_reg + 2'h1;
			// Idle data keeps changing so nothing stale looks valid
			o_channel_data_in <= ~o_channel_data_in;
			if (i_start && !o_busy)
				left_reg <= i_count;
			else if (left_reg != 8'h00 && gap_reg == 2'h2)
				o_channel_data_in <= left_reg[0] ^ left_reg[2];
			else if (left_reg != 8'h00 && gap_reg == 2'h3)
			begin
				// Data bit stands through the pulse cycle
				o_channel_data_in <= o_channel_data_in;
				o_gated_input_clock <= 1'b1;
				left_reg <= left_reg - 8'h01;
			end
		end
	end
endmodule

// >>> bench/smoothing_elastic_buffer_tb_top.sv
// Self-checking bench for the smoothing elastic buffer
`timescale 1ns/10ps
module smoothing_elastic_buffer_tb_top;
	import sbuf_pkg::*;
	logic        clk = 0, rst_n = 0;   // Clock and reset
	logic [4:0]  adr = 0;              // Bus address
	logic        rd = 0, wr = 0;       // Bus requests
	logic [31:0] wd = 0, q, v;         // Write, read data
	logic        wreq, gic, din, mbusy;
	logic        eos = 0, pre = 0, arm = 0;  // arm: strobe on next pulse
	logic        dflt = 0, tflt = 0, eclr = 0, st = 0;
	logic        out, out_n, tim, tim_n, cerr, irq;
	logic        mstart = 0, tl = 0;
	logic [7:0]  mcnt = 0;
	logic [3:0]  ewr;                  // Expected write address
	int          mismatches = 0, num_checks = 0, n[5], k;
	logic [4:0]  ra[5] = '{REG_CTRL, REG_STRAP, REG_STATUS,
		REG_MASK, 5'h14};
	logic [31:0] cv[5] = '{32'h0000_0000, 32'h0000_0040,
		32'h0000_0080, 32'h0000_00C0, 32'h0000_0100};

	// 100 ns clock
	always #50 clk = ~clk;

	sbuf_upstream_model i_up (.i_clk(clk), .i_reset_n(rst_n),
		.i_start(mstart), .i_count(mcnt),
		.o_gated_input_clock(gic), .o_channel_data_in(din),
		.o_busy(mbusy));

	sbuf_core i_dut (.i_clk(clk), .i_reset_n(rst_n),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .o_avs_readdata(q),
		.o_avs_waitrequest(wreq), .i_channel_data_in(din),
		.i_gated_input_clock(gic), .i_end_of_scan(eos),
		.i_word_count_preset(pre), .i_word24_bit0_strobe(arm && gic),
		.i_data_driver_fault(dflt), .i_timing_driver_fault(tflt),
		.i_error_clear(eclr), .i_self_test_active(st),
		.o_buffered_data_out(out), .o_buffered_data_out_n(out_n),
		.o_timing_clock_out(tim), .o_timing_clock_out_n(tim_n),
		.o_card_error_out(cerr), .o_irq(irq));

	// Verdict and end of run
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Compare one value
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask

	// One bus cycle, held until waitrequest is low
	task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		for (i = 0; i < 50; i++)
		begin
			@(posedge clk);
			if (wreq === 1'b0)
				break;
		end
		if (i == 50)
		begin
			mismatches++;
			summarize;
		end
		v = q;
		rd <= 0;
		wr <= 0;
	endtask

	task rreg(input logic [4:0] a); acc(0, a, 0); endtask
	task wreg(input logic [4:0] a, input logic [31:0] d); acc(1, a, d);
	endtask

	// Send pulses, wait for the model to finish
	task burst(input logic [7:0] c);
		int i;
		@(posedge clk);
		mstart <= 1;
		mcnt <= c;
		@(posedge clk);
		mstart <= 0;
		for (i = 0; i < 2000; i++)
		begin
			@(negedge clk);
			if (mbusy === 1'b0)
				break;
		end
		if (i == 2000)
		begin
			mismatches++;
			summarize;
		end
		repeat (3) @(posedge clk);
		ewr = ewr + c[3:0];
		rreg(REG_STATE);
		chk("write addr", ewr, v[3:0]);
	endtask

	// Settle helper after single-bit input pulses: wait three clocks
	task settle; repeat (3) @(posedge clk); endtask

	// Count timing output changes over a fixed window
	task tog(output int c);
		c = 0;
		repeat (2000)
		begin
			@(negedge clk);
			if (tim !== tl)
				c++;
			tl = tim;
		end
		chk("tim_n", !tim, tim_n);
		chk("out_n", !out, out_n);
	endtask

	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1;
		rreg(REG_STATE);
		chk("state reset", 32'h0000_0008, v[12:0]);
		for (k = 0; k < 5; k++)
		begin
			rreg(ra[k]);
			chk("reg reset", 0, v);
		end
		chk("card err", 0, cerr);
		$display("test reset done");
		ewr = 4'h8;
		burst(5);
		wreg(REG_CTRL, 32'h0000_0400);
		burst(3);
		@(posedge clk) eos <= 1;
		@(posedge clk) eos <= 0;
		wreg(REG_STRAP, 32'h0000_0200);
		burst(3);
		wreg(REG_STRAP, 32'h0000_0201);
		burst(0);
		ewr = ewr - 4'h0;
		@(posedge clk) mstart <= 0;
		burst_inh();
		@(posedge clk) pre <= 1;
		@(posedge clk) pre <= 0;
		wreg(REG_STRAP, 32'h0000_0001);
		burst_inh();
		wreg(REG_CTRL, 0);
		wreg(REG_STRAP, 32'h0000_03FF);
		burst(8);
		$display("test write path done");
		wreg(REG_MASK, 2);
		@(posedge clk) dflt <= 1;
		@(posedge clk) dflt <= 0;
		settle;
		chk("card err", 1, cerr);
		chk("irq", 1, irq);
		rreg(REG_STATUS);
		chk("status", 2, v);
		wreg(REG_STATUS, 2);
		settle;
		chk("irq clr", 0, irq);
		@(posedge clk) eclr <= 1;
		@(posedge clk) eclr <= 0;
		settle;
		chk("err clear", 0, cerr);
		@(posedge clk) tflt <= 1;
		@(posedge clk) tflt <= 0;
		settle;
		chk("card err", 1, cerr);
		chk("irq mask", 0, irq);
		@(posedge clk) eclr <= 1;
		@(posedge clk) eclr <= 0;
		st <= 1;
		@(posedge clk) {dflt, tflt} <= 2'b11;
		@(posedge clk) {dflt, tflt} <= 2'b00;
		settle;
		chk("self test", 0, cerr);
		@(posedge clk) st <= 0;
		eclr <= 1;
		@(posedge clk) eclr <= 0;
		settle;
		chk("after test", 0, cerr);
		$display("test errors done");
		@(posedge clk) arm <= 1;
		burst(1);
		arm <= 0;
		for (k = 0; k < 5; k++)
		begin
			wreg(REG_CTRL, cv[k]);
			tog(n[k]);
		end
		rreg(REG_STATUS);
		chk("compare", 0, v[ST_CMP]);
		chk("tim", 1, n[0] > 0);
		chk("pre B", 1, n[1] * 8 < n[0]);
		chk("pre D", 1, n[3] * 8 < n[2]);
		chk("freq", 1, n[4] * 4 < n[0] * 3);
		$display("test clocks done");
		summarize;
	end

	// Pulses that the inhibit must swallow
	task burst_inh;
		ewr = ewr - 4'h3;
		burst(3);
	endtask
endmodule

// >>> design/sbuf_core.sv
// Smoothing elastic buffer with digital rate smoothing loop and diagnostics
`timescale 1ns/10ps
module sbuf_core
	import sbuf_pkg::*;
#(
	parameter logic [NCO_W-1:0] NOM_INC_A = 24'h10_0000,
	parameter logic [NCO_W-1:0] NOM_INC_B = 24'h08_0000
)
(
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic [4:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_channel_data_in,
	input  wire logic        i_gated_input_clock,
	input  wire logic        i_end_of_scan,
	input  wire logic        i_word_count_preset,
	input  wire logic        i_word24_bit0_strobe,
	input  wire logic        i_data_driver_fault,
	input  wire logic        i_timing_driver_fault,
	input  wire logic        i_error_clear,
	input  wire logic        i_self_test_active,
	output logic             o_buffered_data_out,
	output logic             o_buffered_data_out_n,
	output logic             o_timing_clock_out,
	output logic             o_timing_clock_out_n,
	output logic             o_card_error_out,
	output logic             o_irq
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// Software state
	logic [12:0]       ctrl_reg;      // Selector bank
	logic [9:0]        strap_reg;     // Fill-bit strap value
	logic [2:0]        status_reg;    // Sticky events
	logic [2:0]        mask_reg;      // Interrupt enables
	logic              ack_reg;       // Bus answer strobe
	logic [31:0]       rdata_reg;     // Bus read data
	// Buffer state
	logic [15:0]       store_reg;     // Elastic store
	logic [ADDR_W-1:0] wr_addr_reg;   // Write address
	logic [ADDR_W-1:0] rd_addr_reg;   // Read address
	logic              out_reg;       // Output data buffer
	// Loop state
	logic [NCO_W-1:0]  acc_reg;       // Oscillator phase
	logic [NCO_W-1:0]  integ_reg;     // Loop integrator (signed)
	logic [3:0]        pd_reg;        // Phase error (signed)
	logic              ref_d_reg;     // Reference delayed
	logic              var_d_reg;     // Variable delayed
	logic [3:0]        pre_reg;       // Divide-by-16 stage
	logic [3:0]        div_reg;       // Power-of-two divider
	// Coarse rate conversion
	logic [9:0]        word_reg;      // Word counter
	// Diagnostics
	logic [ADDR_W-1:0] lat_addr_reg;  // Captured write address
	logic              lat_data_reg;  // Captured data bit
	logic              busy_reg;      // Compare in progress
	logic              cmp_en_reg;    // Compare enable
	logic              cmp_err_reg;   // Data compare error
	logic              ddrv_reg;      // Data driver error latch
	logic              tdrv_reg;      // Timing driver error latch
	logic              card_err_reg;  // Card error output

	// Selector fields
	logic [1:0] gain_sel;
	logic [1:0] tc_sel;
	logic [1:0] osc_sel;
	logic [1:0] pre_sel;
	logic [1:0] freq_sel;
	logic [1:0] rate_sel;
	logic       pol_sel;
	assign gain_sel = ctrl_reg[CTL_GAIN +: 2];
	assign tc_sel   = ctrl_reg[CTL_TC +: 2];
	assign osc_sel  = ctrl_reg[CTL_OSC +: 2];
	assign pre_sel  = ctrl_reg[CTL_PRE +: 2];
	assign freq_sel = ctrl_reg[CTL_FREQ +: 2];
	assign rate_sel = ctrl_reg[CTL_RATE +: 2];
	assign pol_sel  = ctrl_reg[CTL_POL];

	// Bit-reversed word count for an even spread of deletions
	logic [9:0] word_rev;
	genvar g;
	generate
		for (g = 0; g < 10; g++)
		begin : rev
			assign word_rev[g] = word_reg[9 - g];
		end
	endgenerate

	// Gated clock acceptance
	logic inhibit;
	logic wr_tick;
	assign inhibit = (rate_sel == RATE_CONVERT_POSITION)
		&& (word_rev < strap_reg);
	assign wr_tick = i_gated_input_clock && !inhibit;

	// Oscillator, prescaler and output divider
	logic [NCO_W-1:0] nom_inc;
	logic [NCO_W-1:0] adjust;
	logic [NCO_W:0]   acc_sum;
	logic             osc_tick;
	logic             pre16;
	logic             pre_tick;
	logic [3:0]       div_mask;
	logic             rd_tick;
	assign nom_inc  = osc_sel[0] ? NOM_INC_B : NOM_INC_A;
	assign adjust   = ($signed(integ_reg) >>> (TC_BASE + int'(tc_sel)))
		+ (NCO_W'($signed(pd_reg)) <<< gain_sel);
	assign acc_sum  = {1'b0, acc_reg} + {1'b0, nom_inc + adjust};
	assign osc_tick = acc_sum[NCO_W];
	assign pre16    = pre_sel[0];
	assign pre_tick = pre16 ? (osc_tick && pre_reg == PRE_FULL) : osc_tick;
	assign div_mask = 4'((5'h02 << freq_sel) - 5'h01);
	assign rd_tick  = pre_tick && ((div_reg & div_mask) == div_mask);

	// Phase detector inputs and their falling edges
	logic pd_ref;
	logic pd_var;
	logic ref_fall;
	logic var_fall;
	assign pd_ref   = !wr_addr_reg[ADDR_W-1];
	assign pd_var   = rd_addr_reg[ADDR_W-1];
	assign ref_fall = ref_d_reg && !pd_ref;
	assign var_fall = var_d_reg && !pd_var;

	// Write side of the store
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			store_reg   <= 16'h0000;
			wr_addr_reg <= WR_RESET;
		end
		else if (wr_tick)
		begin
			store_reg[wr_addr_reg] <= i_channel_data_in;
			wr_addr_reg <= wr_addr_reg + 4'h1;
		end
	end

	// Read side and output buffer
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			rd_addr_reg <= RD_RESET;
			out_reg     <= 1'b0;
		end
		else if (rd_tick)
		begin
			out_reg     <= store_reg[rd_addr_reg];
			rd_addr_reg <= rd_addr_reg + 4'h1;
		end
	end

	// Phase detector: lead/lag count between the two falling edges
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			ref_d_reg <= 1'b0;
			var_d_reg <= 1'b0;
			pd_reg    <= 4'h0;
		end
		else
		begin
			ref_d_reg <= pd_ref;
			var_d_reg <= pd_var;
			// Read leading raises count, write leading lowers it
			if (var_fall && !ref_fall && $signed(pd_reg) < PD_LIM)
				pd_reg <= pd_reg - 4'h1 + 4'h2;
			else if (ref_fall && !var_fall && $signed(pd_reg) > -PD_LIM)
				pd_reg <= pd_reg - 4'h1;
		end
	end

	// Integrator slews the oscillator slowly toward lock
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			integ_reg <= '0;
		else if (osc_tick)
			// Positive error means read leads: pull frequency down
			integ_reg <= integ_reg - NCO_W'($signed(pd_reg));
	end

	// Oscillator, prescaler and divider counters
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			acc_reg <= '0;
			pre_reg <= 4'h0;
			div_reg <= 4'h0;
		end
		else
		begin
			acc_reg <= acc_sum[NCO_W-1:0];
			if (osc_tick)
				pre_reg <= pre_reg + 4'h1;
			if (pre_tick)
				div_reg <= div_reg + 4'h1;
		end
	end

	// Coarse rate word counter
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			word_reg <= 10'h000;
		else if (i_word_count_preset)
			word_reg <= 10'h000;
		else if (i_end_of_scan)
			word_reg <= word_reg + 10'h001;
	end

	// Address compare diagnostic
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			lat_addr_reg <= 4'h0;
			lat_data_reg <= 1'b0;
			busy_reg     <= 1'b0;
			cmp_en_reg   <= 1'b0;
		end
		else
		begin
			cmp_en_reg <= 1'b0;
			// New capture only when the previous compare has finished
			if (i_word24_bit0_strobe && !busy_reg)
			begin
				lat_addr_reg <= wr_addr_reg;
				lat_data_reg <= i_channel_data_in;
				busy_reg     <= 1'b1;
			end
			else if (busy_reg && rd_tick && rd_addr_reg == lat_addr_reg)
			begin
				cmp_en_reg <= 1'b1;
				busy_reg   <= 1'b0;
			end
		end
	end

	// Error latches: a set in the clear cycle wins
	logic cmp_set;
	assign cmp_set = cmp_en_reg && (out_reg != lat_data_reg);
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			cmp_err_reg <= 1'b0;
			ddrv_reg    <= 1'b0;
			tdrv_reg    <= 1'b0;
		end
		else
		begin
			if (cmp_set)
				cmp_err_reg <= 1'b1;
			else if (i_error_clear)
				cmp_err_reg <= 1'b0;
			if (i_data_driver_fault)
				ddrv_reg <= 1'b1;
			else if (i_error_clear)
				ddrv_reg <= 1'b0;
			if (i_timing_driver_fault)
				tdrv_reg <= 1'b1;
			else if (i_error_clear)
				tdrv_reg <= 1'b0;
		end
	end

	// Composite card error
	logic [2:0] err_vec;
	assign err_vec = {tdrv_reg, ddrv_reg, cmp_err_reg};
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			card_err_reg <= 1'b0;
		else if (i_self_test_active)
			card_err_reg <= &err_vec;
		else
			card_err_reg <= |err_vec;
	end

	// Bus answer: one wait state for every access
	logic bus_req;
	logic bus_wr;
	assign bus_req = (i_avs_read || i_avs_write) && !ack_reg;
	assign bus_wr  = i_avs_write && ack_reg;
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= bus_req;
			if (bus_req && i_avs_read)
			begin
				unique case (i_avs_address)
					REG_CTRL:   rdata_reg <= {19'h0_0000, ctrl_reg};
					REG_STRAP:  rdata_reg <= {22'h00_0000, strap_reg};
					REG_STATUS: rdata_reg <= {29'h0000_0000, status_reg};
					REG_MASK:   rdata_reg <= {29'h0000_0000, mask_reg};
					REG_STATE:  rdata_reg <= {18'h0_0000, busy_reg,
						card_err_reg, pd_reg, rd_addr_reg, wr_addr_reg};
					default:    rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Configuration registers
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			ctrl_reg  <= CTRL_RESET;
			strap_reg <= STRAP_RESET;
			mask_reg  <= MASK_RESET;
		end
		else if (bus_wr)
		begin
			if (i_avs_address == REG_CTRL)
				ctrl_reg <= i_avs_writedata[12:0];
			if (i_avs_address == REG_STRAP)
				strap_reg <= i_avs_writedata[9:0];
			if (i_avs_address == REG_MASK)
				mask_reg <= i_avs_writedata[2:0];
		end
	end

	// Sticky status, write one to clear, new event wins
	logic [2:0] ev_vec;
	logic [2:0] clr_vec;
	assign ev_vec  = {i_timing_driver_fault, i_data_driver_fault, cmp_set};
	assign clr_vec = (bus_wr && i_avs_address == REG_STATUS)
		? i_avs_writedata[2:0] : 3'h0;
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			status_reg <= 3'h0;
		else
			status_reg <= ev_vec | (status_reg & ~clr_vec);
	end

	// Outputs
	assign o_avs_waitrequest     = (i_avs_read || i_avs_write) && !ack_reg;
	assign o_avs_readdata        = rdata_reg;
	assign o_buffered_data_out   = out_reg ^ pol_sel;
	assign o_buffered_data_out_n = !(out_reg ^ pol_sel);
	assign o_timing_clock_out    = div_reg[freq_sel];
	assign o_timing_clock_out_n  = !div_reg[freq_sel];
	assign o_card_error_out      = card_err_reg;
	assign o_irq                 = |(status_reg & mask_reg);

	// Checks
	wr_advance_a: assert property (wr_tick |=>
		wr_addr_reg == $past(wr_addr_reg) + 4'h1)
		else $error("write address did not advance");
	rate_inhibit_a: assert property (
		(i_gated_input_clock && inhibit) |=> $stable(wr_addr_reg))
		else $error("inhibited gated clock was written");
	rd_advance_a: assert property (rd_tick |=>
		rd_addr_reg == $past(rd_addr_reg) + 4'h1
		&& out_reg == $past(store_reg[rd_addr_reg]))
		else $error("read side did not step");
	data_pair_a: assert property (
		o_buffered_data_out != o_buffered_data_out_n)
		else $error("data outputs not complementary");
	reset_offset_a: assert property ($past(!i_reset_n) |->
		wr_addr_reg - rd_addr_reg == 4'h8)
		else $error("counters not eight apart after reset");
	err_any_a: assert property (
		(!i_self_test_active && |err_vec) |=> o_card_error_out)
		else $error("card error missing");
	self_test_a: assert property (
		(i_self_test_active && !(&err_vec)) |=> !o_card_error_out)
		else $error("card error in self-test without all inputs");
	latch_hold_a: assert property (
		(ddrv_reg && !i_error_clear) |=> ddrv_reg)
		else $error("driver error latch dropped");
	tlatch_hold_a: assert property (
		(tdrv_reg && !i_error_clear) |=> tdrv_reg)
		else $error("timing driver error latch dropped");
	bus_answer_a: assert property (
		(i_avs_read || i_avs_write) |-> ##[0:1] !o_avs_waitrequest)
		else $error("bus answer late");
endmodule

// >>> shared/sbuf_pkg.sv
// Constants, register map and field layout of the smoothing elastic buffer
package sbuf_pkg;
	// Store geometry
	localparam int          ADDR_W      = 4;
	localparam logic [3:0]  WR_RESET    = 4'h8;
	localparam logic [3:0]  RD_RESET    = 4'h0;
	// Register byte offsets
	localparam logic [4:0]  REG_CTRL    = 5'h00;
	localparam logic [4:0]  REG_STRAP   = 5'h04;
	localparam logic [4:0]  REG_STATUS  = 5'h08;
	localparam logic [4:0]  REG_MASK    = 5'h0C;
	localparam logic [4:0]  REG_STATE   = 5'h10;
	// Control field positions (two bits per selector, one bit for polarity)
	localparam int          CTL_GAIN    = 0;
	localparam int          CTL_TC      = 2;
	localparam int          CTL_OSC     = 4;
	localparam int          CTL_PRE     = 6;
	localparam int          CTL_FREQ    = 8;
	localparam int          CTL_RATE    = 10;
	localparam int          CTL_POL     = 12;
	localparam logic [12:0] CTRL_RESET  = 13'h0000;
	localparam logic [9:0]  STRAP_RESET = 10'h000;
	localparam logic [2:0]  MASK_RESET  = 3'h0;
	// Rate mode position that enables coarse conversion
	localparam logic [1:0]  RATE_CONVERT_POSITION = 2'h1;
	// Status bit positions
	localparam int          ST_CMP      = 0;
	localparam int          ST_DDRV     = 1;
	localparam int          ST_TDRV     = 2;
	// Oscillator model
	localparam int          NCO_W       = 24;
	localparam int          PD_LIM      = 7;
	localparam int          TC_BASE     = 6;
	localparam logic [3:0]  PRE_FULL    = 4'hF;
endpackage
